// file: core/pcm_defines.vh
// constants for the panel/crt display output mux
`ifndef PCM_DEFINES_VH
`define PCM_DEFINES_VH
// apb register byte offsets
`define PCM_REG_CTRL      12'h000
`define PCM_REG_TIMING    12'h004
`define PCM_REG_PIXEL     12'h008
`define PCM_REG_STATUS    12'h00C
`define PCM_REG_IOSTAT    12'h010
// ctrl fields
`define PCM_CTRL_MODE_LSB 0
`define PCM_CTRL_TFT_BIT  2
`define PCM_CTRL_RST      32'h0000_0000
// display modes
`define PCM_MODE_LCD      2'h0
`define PCM_MODE_PLASMA   2'h1
`define PCM_MODE_CRT      2'h2
// timing register defaults: active pixels, total pixels per line; lines per frame is a fixed constant
`define PCM_TIMING_RST    32'h0020_0028
`define PCM_LINES_DEF     8'h10
`define PCM_HSYNC_LEN     8'h04
`define PCM_VSYNC_LINES   8'h02
// host i/o port addresses seen by the palette strobes, plus status port 3c2
`define PCM_IO_PEL_MASK   10'h3C6
`define PCM_IO_RD_ADDR    10'h3C7
`define PCM_IO_WR_ADDR    10'h3C8
`define PCM_IO_DATA       10'h3C9
`define PCM_IO_STAT0      10'h3C2
`define PCM_STAT0_SENSE   4
`endif

// file: core/pcm_display_mux.v
// display output stage: panel / plasma / crt pin mux with timing and palette strobes
`timescale 1ns/1ps
`include "pcm_defines.vh"

module pcm_display_mux
(
   input  wire        clk_sys_i,          // 20 mhz system clock
   input  wire        sys_rst_i,          // synchronous reset, active high
   input  wire        psel_i,             // apb select
   input  wire        penable_i,          // apb enable
   input  wire        pwrite_i,           // apb direction
   input  wire [11:0] paddr_i,            // apb byte address
   input  wire [31:0] pwdata_i,           // apb write data
   output reg  [31:0] prdata_o,           // apb read data
   output reg         pready_o,           // apb ready
   output reg         pslverr_o,          // apb error on unmapped address
   input  wire        power_down_n_i,     // pin, stop refresh when low
   input  wire        vref_grounded_i,    // pin, reference tied to ground
   input  wire        monitor_sense_i,    // pin, monitor detect / full scale set
   input  wire        host_io_rd_i,       // host i/o read strobe, same clock
   input  wire        host_io_wr_i,       // host i/o write strobe, same clock
   input  wire [9:0]  host_io_addr_i,     // host i/o address, same clock
   output reg         panel_or_tube_select_o,  // 1 crt, 0 lcd
   output reg         pixel_clock_o,           // ramdac pixel clock
   output reg         column_shift_clock_o,    // panel shift clock
   output reg         gray_weight_clock_o,     // weight clock / video enable
   output reg         line_latch_or_hsync_o,   // latch pulse / hsync
   output reg         frame_start_or_vsync_o,  // frame pulse / vsync
   output reg         frame_toggle_or_blank_o, // ac drive / blank
   output reg  [3:0]  lower_panel_data_o,      // lower panel data / low nibble
   output reg  [3:0]  upper_panel_data_o,      // upper panel data / high nibble
   output reg         palette_read_n_o,        // palette read strobe / tft bit 9
   output reg         palette_write_n_o,       // palette write strobe
   output reg         internal_dac_en_o        // internal ramdac enabled
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg  [31:0] ctrl;
   reg  [31:0] timing;
   reg  [8:0]  pixel;
   // async pins: bit 0 power down, bit 1 grounded reference, bit 2 sense
   wire [2:0]  pin_async = {monitor_sense_i, vref_grounded_i, power_down_n_i};
   wire [2:0]  pin_sync;
   reg  [7:0]  h_cnt;
   reg  [7:0]  v_cnt;
   reg         phase;
   reg         frame_ac;
   reg  [1:0]  weight_cnt;

   wire [1:0]  mode      = ctrl[`PCM_CTRL_MODE_LSB +: 2];
   wire        is_lcd    = (mode == `PCM_MODE_LCD);
   wire        is_plasma = (mode == `PCM_MODE_PLASMA);
   wire        is_crt    = (mode == `PCM_MODE_CRT);
   wire        tft_mode  = ctrl[`PCM_CTRL_TFT_BIT] & is_lcd;
   wire [7:0]  h_total   = timing[7:0];
   wire [7:0]  h_active  = timing[23:16];
   wire [7:0]  v_total   = `PCM_LINES_DEF;
   wire        refresh_on = pin_sync[0];
   wire        ext_dac    = pin_sync[1];

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // two stages per pin; only the second stage feeds any logic
   genvar      gi;

   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_pin_sync
         reg [1:0] stage;
         always @(posedge clk_sys_i)
         begin
            if (sys_rst_i)
               stage <= 2'h0;
            else
               stage <= {stage[0], pin_async[gi]};
         end
         assign pin_sync[gi] = stage[1];
      end
   endgenerate

   // ---------------------------------------------------------------
   // apb slave, zero wait states
   // ---------------------------------------------------------------
   wire setup  = psel_i & ~penable_i;
   wire mapped = (paddr_i == `PCM_REG_CTRL) | (paddr_i == `PCM_REG_TIMING) |
                 (paddr_i == `PCM_REG_PIXEL) | (paddr_i == `PCM_REG_STATUS) |
                 (paddr_i == `PCM_REG_IOSTAT);
   reg  [31:0] next_prdata;

   always @*
   begin
      case (paddr_i)
         `PCM_REG_CTRL:   next_prdata = ctrl;
         `PCM_REG_TIMING: next_prdata = timing;
         `PCM_REG_PIXEL:  next_prdata = {23'h0, pixel};
         `PCM_REG_STATUS: next_prdata = {12'h000, v_cnt, h_cnt, frame_ac, ext_dac,
                                         refresh_on, is_crt};
         // port 3c2 image: sense only with external ramdac
         `PCM_REG_IOSTAT: next_prdata = {27'h0, ext_dac & pin_sync[2], 4'h0};
         default:         next_prdata = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         ctrl      <= `PCM_CTRL_RST;
         timing    <= `PCM_TIMING_RST;
         pixel     <= 9'h000;
         prdata_o  <= 32'h0000_0000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o  <= setup;
         pslverr_o <= setup & ~mapped;
         if (setup & ~pwrite_i)
            prdata_o <= next_prdata;
         if (psel_i & penable_i & pready_o & pwrite_i)
         begin
            if (paddr_i == `PCM_REG_CTRL)
               ctrl <= {29'h0, pwdata_i[2:0]};
            if (paddr_i == `PCM_REG_TIMING)
               timing <= {8'h0, pwdata_i[23:16], 8'h0, pwdata_i[7:0]};
            if (paddr_i == `PCM_REG_PIXEL)
               pixel <= pwdata_i[8:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // scan timing
   // ---------------------------------------------------------------
   wire line_end  = phase & (h_cnt >= h_total - 8'h01);
   wire frame_end = line_end & (v_cnt >= v_total - 8'h01);
   wire active    = (h_cnt < h_active);
   wire hsync     = (h_cnt >= h_total - `PCM_HSYNC_LEN);
   wire vsync     = (v_cnt < `PCM_VSYNC_LINES);

   always @(posedge clk_sys_i)
   begin
      if (sys_rst_i | ~refresh_on)
      begin
         phase      <= 1'b0;
         h_cnt      <= 8'h00;
         v_cnt      <= 8'h00;
         weight_cnt <= 2'h0;
         if (sys_rst_i)
            frame_ac <= 1'b0;
      end
      else
      begin
         phase <= ~phase;
         if (line_end)
            h_cnt <= 8'h00;
         else if (phase)
            h_cnt <= h_cnt + 8'h01;
         if (frame_end)
         begin
            v_cnt      <= 8'h00;
            frame_ac   <= ~frame_ac;
            weight_cnt <= weight_cnt + 2'h1;
         end
         else if (line_end)
            v_cnt <= v_cnt + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // pin functions per mode
   // ---------------------------------------------------------------
   // read-address port 3c7 gives no read strobe
   wire        pal_rd_hit = host_io_rd_i &
                            ((host_io_addr_i == `PCM_IO_PEL_MASK) |
                             (host_io_addr_i == `PCM_IO_WR_ADDR) |
                             (host_io_addr_i == `PCM_IO_DATA));
   wire        pal_wr_hit = host_io_wr_i &
                            (host_io_addr_i >= `PCM_IO_PEL_MASK) &
                            (host_io_addr_i <= `PCM_IO_DATA);

   reg         next_select;
   reg         next_pixel_clock;
   reg         next_shift_clock;
   reg         next_weight_clock;
   reg         next_line_latch;
   reg         next_frame_start;
   reg         next_frame_toggle;
   reg  [3:0]  next_lower;
   reg  [3:0]  next_upper;
   reg         next_palette_read_n;

   always @*
   begin
      // quiet levels first: an unused mode code leaves every pin idle except the palette strobes and the dac enable
      next_select         = 1'b0;
      next_pixel_clock    = 1'b0;
      next_shift_clock    = 1'b0;
      next_weight_clock   = 1'b0;
      next_line_latch     = 1'b0;
      next_frame_start    = 1'b0;
      next_frame_toggle   = 1'b0;
      next_lower          = 4'h0;
      next_upper          = 4'h0;
      next_palette_read_n = ~pal_rd_hit;
      case (mode)
         `PCM_MODE_LCD:
         begin
            next_shift_clock  = refresh_on & active & phase;
            // weight clock runs at frame/4 rate for pwm gray levels
            next_weight_clock = refresh_on & weight_cnt[1];
            next_line_latch   = refresh_on & line_end;
            next_frame_start  = refresh_on & (v_cnt == 8'h00) & hsync;
            next_frame_toggle = frame_ac;
            next_lower        = refresh_on ? pixel[3:0] : 4'h0;
            next_upper        = refresh_on ? pixel[7:4] : 4'h0;
            // tft reuses the read strobe pin as data bit 9, true polarity
            if (tft_mode)
               next_palette_read_n = refresh_on & pixel[8];
         end
         `PCM_MODE_PLASMA:
         begin
            next_shift_clock  = refresh_on & active & phase;
            next_weight_clock = refresh_on & active;
            next_line_latch   = refresh_on & hsync;
            next_frame_start  = refresh_on & vsync;
            // lower nibble reserved in plasma, held low
            next_upper        = refresh_on ? pixel[7:4] : 4'h0;
         end
         `PCM_MODE_CRT:
         begin
            next_select       = 1'b1;
            next_pixel_clock  = refresh_on & phase;
            next_line_latch   = refresh_on & hsync;
            next_frame_start  = refresh_on & vsync;
            next_frame_toggle = ~active | ~refresh_on;
            next_lower        = refresh_on ? pixel[3:0] : 4'h0;
            next_upper        = refresh_on ? pixel[7:4] : 4'h0;
         end
         default:
         begin
            next_select       = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // output registers, every pin straight from a flip-flop
   // ---------------------------------------------------------------
   always @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         panel_or_tube_select_o  <= 1'b0;
         pixel_clock_o           <= 1'b0;
         column_shift_clock_o    <= 1'b0;
         gray_weight_clock_o     <= 1'b0;
         line_latch_or_hsync_o   <= 1'b0;
         frame_start_or_vsync_o  <= 1'b0;
         frame_toggle_or_blank_o <= 1'b0;
         lower_panel_data_o      <= 4'h0;
         upper_panel_data_o      <= 4'h0;
         palette_read_n_o        <= 1'b1;
         palette_write_n_o       <= 1'b1;
         internal_dac_en_o       <= 1'b0;
      end
      else
      begin
         // all pins but the dac enable and write strobe follow one mode field, so they switch in the same cycle
         panel_or_tube_select_o  <= next_select;
         internal_dac_en_o       <= ~ext_dac;
         pixel_clock_o           <= next_pixel_clock;
         column_shift_clock_o    <= next_shift_clock;
         gray_weight_clock_o     <= next_weight_clock;
         line_latch_or_hsync_o   <= next_line_latch;
         frame_start_or_vsync_o  <= next_frame_start;
         frame_toggle_or_blank_o <= next_frame_toggle;
         lower_panel_data_o      <= next_lower;
         upper_panel_data_o      <= next_upper;
         palette_read_n_o        <= next_palette_read_n;
         palette_write_n_o       <= ~pal_wr_hit;
      end
   end

endmodule

// file: testbench/pcm_display_mux_monitor.sv
// assertion checker for the display output mux
`timescale 1ns/1ps
`include "pcm_defines.vh"
module pcm_display_mux_monitor
(
   input wire        clk_sys_i,              // clock
   input wire        sys_rst_i,              // reset
   input wire        psel_i,                 // apb
   input wire        penable_i,              // apb
   input wire        pwrite_i,               // apb
   input wire [11:0] paddr_i,                // apb
   input wire [31:0] pwdata_i,               // apb
   input wire        pready_o,               // apb
   input wire        power_down_n_i,         // pin
   input wire        host_io_rd_i,           // host
   input wire        host_io_wr_i,           // host
   input wire [9:0]  host_io_addr_i,         // host
   input wire        panel_or_tube_select_o, // pin
   input wire        pixel_clock_o,          // pin
   input wire [3:0]  lower_panel_data_o,     // pin
   input wire        palette_read_n_o,       // pin
   input wire        palette_write_n_o       // pin
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   reg  [2:0] ctrl;
   wire       wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == `PCM_REG_CTRL;
   wire [9:0] a = host_io_addr_i;
   wire       rd_pal = host_io_rd_i && (a == 10'h3C6 || a == 10'h3C8 || a == 10'h3C9);
   wire       is_crt = ctrl[1:0] == `PCM_MODE_CRT;
   // shadow of mode and tft bits, since the checker sees no internal state
   always @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         ctrl <= 3'h0;
      else if (wr_ctrl)
         ctrl <= pwdata_i[2:0];
   end
   AST_RD_PAL: assert property (rd_pal && !ctrl[2] |=> !palette_read_n_o)
      else $error("palette read strobe missing");
   AST_WR_PAL: assert property (host_io_wr_i && a >= 10'h3C6 && a <= 10'h3C9 |=> !palette_write_n_o)
      else $error("palette write strobe missing");
   AST_WR_IDLE: assert property (!host_io_wr_i |=> palette_write_n_o)
      else $error("palette write strobe without host write");
   AST_SEL_CRT: assert property (is_crt [*3] |-> panel_or_tube_select_o)
      else $error("tube select low in crt mode");
   AST_SEL_LCD: assert property ((ctrl[1:0] == `PCM_MODE_LCD) [*3] |-> !panel_or_tube_select_o)
      else $error("tube select high in lcd mode");
   AST_PCLK_OFF: assert property ((!is_crt) [*3] |-> !pixel_clock_o)
      else $error("pixel clock outside crt mode");
   AST_PCLK_RUN: assert property ((is_crt && power_down_n_i) [*8] |-> $changed(pixel_clock_o))
      else $error("pixel clock not toggling");
   AST_PDN: assert property ((!power_down_n_i) [*5] |-> !pixel_clock_o && lower_panel_data_o == 4'h0)
      else $error("scan active in power down");
   AST_READY: assert property (psel_i && !penable_i |=> pready_o)
      else $error("apb access not answered");
endmodule

// file: testbench/pcm_panel_model.sv
// panel side: counts frame pulses, ac changes and shift edges
`timescale 1ns/1ps
module pcm_panel_model
(
   input  wire clk_sys_i,     // clock
   input  wire frame_i,       // frame start
   input  wire toggle_i,      // ac drive
   input  wire shift_i,       // shift clock
   input  wire latch_i,       // line latch / hsync
   input  wire weight_i,      // weight clock / video enable
   output int  frames_o = 0,  // frame starts
   output int  toggles_o = 0, // ac changes
   output int  shifts_o = 0,  // shift edges
   output int  latches_o = 0, // latch edges
   output int  weights_o = 0  // weight changes
);
   reg [4:0] last = 5'h00;
   always @(posedge clk_sys_i)
   begin
      frames_o <= frames_o + int'(frame_i && !last[0]);
      toggles_o <= toggles_o + int'(toggle_i != last[1]);
      shifts_o <= shifts_o + int'(shift_i && !last[2]);
      latches_o <= latches_o + int'(latch_i && !last[3]);
      weights_o <= weights_o + int'(weight_i != last[4]);
      last <= {weight_i, latch_i, shift_i, toggle_i, frame_i};
   end
endmodule

// file: testbench/tb.sv
// self-checking bench for the display output mux
`timescale 1ns/1ps
`include "pcm_defines.vh"
module tb;
   reg         clk_sys_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
   reg         pwrite_i = 1'b0, power_down_n_i = 1'b1, vref_grounded_i = 1'b0;
   reg         monitor_sense_i = 1'b0, host_io_rd_i = 1'b0, host_io_wr_i = 1'b0;
   reg  [11:0] paddr_i = 12'h000;
   reg  [31:0] pwdata_i = 32'h0000_0000;
   reg  [9:0]  host_io_addr_i = 10'h000;
   wire [31:0] prdata_o;
   wire [3:0]  lower_panel_data_o, upper_panel_data_o;
   wire        pready_o, pslverr_o, panel_or_tube_select_o, pixel_clock_o, column_shift_clock_o;
   wire        gray_weight_clock_o, line_latch_or_hsync_o, frame_start_or_vsync_o;
   wire        frame_toggle_or_blank_o, palette_read_n_o, palette_write_n_o, internal_dac_en_o;
   int         err_total = 0, tests_run = 0, cyc = 0, fr, tg, sh, f0, t0, s0, m, n;
   int         lt, wt, l0, w0;
   logic [31:0] q, r;
   logic        e;
   pcm_display_mux i_pcm_display_mux
   (
      .clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .power_down_n_i, .vref_grounded_i, .monitor_sense_i,
      .host_io_rd_i, .host_io_wr_i, .host_io_addr_i, .panel_or_tube_select_o, .pixel_clock_o,
      .column_shift_clock_o, .gray_weight_clock_o, .line_latch_or_hsync_o,
      .frame_start_or_vsync_o, .frame_toggle_or_blank_o, .lower_panel_data_o,
      .upper_panel_data_o, .palette_read_n_o, .palette_write_n_o, .internal_dac_en_o
   );
   pcm_panel_model i_pcm_panel_model
   (
      .clk_sys_i, .frame_i(frame_start_or_vsync_o), .toggle_i(frame_toggle_or_blank_o),
      .shift_i(column_shift_clock_o), .latch_i(line_latch_or_hsync_o),
      .weight_i(gray_weight_clock_o), .frames_o(fr), .toggles_o(tg), .shifts_o(sh),
      .latches_o(lt), .weights_o(wt)
   );
   initial
      forever #25 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         report_and_stop;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do @(posedge clk_sys_i); while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic pclk(input int k);
      logic p;
      p = pixel_clock_o;
      n = 0;
      repeat (k)
      begin
         @(posedge clk_sys_i);
         n += int'(pixel_clock_o !== p);
         p = pixel_clock_o;
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      r = $urandom(5097);
      repeat (10) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_sys_i);
      check("select", panel_or_tube_select_o, 0);
      check("rd strobe", palette_read_n_o, 1);
      apb(0, 12'h014, 0);
      check("unmapped err", e, 1);
      check("unmapped rd", q, 0);
      check("int dac on", internal_dac_en_o, 1);
      $display("done reset");
      for (m = 0; m < 3; m++)
      begin
         r = $urandom & 32'h0000_00FF;
         apb(1, `PCM_REG_CTRL, m);
         apb(1, `PCM_REG_PIXEL, r);
         repeat (6) @(posedge clk_sys_i);
         apb(0, `PCM_REG_STATUS, 0);
         check("crt flag", q[0], m == 2);
         check("select", panel_or_tube_select_o, m == 2);
         check("upper", upper_panel_data_o, r[7:4]);
         check("lower", lower_panel_data_o, m == 1 ? 4'h0 : r[3:0]);
         pclk(8);
         check("pclk", n, m == 2 ? 8 : 0);
      end
      $display("done modes");
      apb(1, `PCM_REG_CTRL, 0);
      repeat (1300) @(posedge clk_sys_i);
      f0 = fr;
      t0 = tg;
      s0 = sh;
      l0 = lt;
      w0 = wt;
      // window is two whole frames, so counts are exact
      repeat (2560) @(posedge clk_sys_i);
      check("frames", fr - f0, 2);
      check("ac", tg - t0, 2);
      check("shifts", sh - s0, 1024);
      check("latches", lt - l0, 32);
      check("weight", wt - w0, 1);
      for (m = 0; m < 24; m++)
      begin
         n = 'h3C0 + m / 2;
         host_io_addr_i <= n[9:0];
         host_io_rd_i <= m % 2 == 0;
         host_io_wr_i <= m % 2 == 1;
         @(posedge clk_sys_i);
         host_io_rd_i <= 1'b0;
         host_io_wr_i <= 1'b0;
         @(posedge clk_sys_i);
         e = m % 2 == 0 && (n == 'h3C6 || n == 'h3C8 || n == 'h3C9);
         check("rd strobe", palette_read_n_o, !e);
         e = m % 2 == 1 && n >= 'h3C6 && n <= 'h3C9;
         check("wr strobe", palette_write_n_o, !e);
      end
      apb(1, `PCM_REG_CTRL, 4);
      for (m = 0; m < 2; m++)
      begin
         apb(1, `PCM_REG_PIXEL, m << 8);
         repeat (4) @(posedge clk_sys_i);
         check("tft bit", palette_read_n_o, m[0]);
      end
      $display("done strobes");
      r = $urandom;
      vref_grounded_i <= 1'b1;
      monitor_sense_i <= r[0];
      repeat (4) @(posedge clk_sys_i);
      apb(0, `PCM_REG_IOSTAT, 0);
      check("sense", q[4], r[0]);
      check("int dac", internal_dac_en_o, 0);
      vref_grounded_i <= 1'b0;
      apb(1, `PCM_REG_CTRL, 2);
      power_down_n_i <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      pclk(20);
      check("pclk idle", n, 0);
      power_down_n_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      pclk(4);
      check("pclk back", n, 4);
      $display("done power");
      repeat (100) @(posedge clk_sys_i);
      f0 = fr;
      t0 = tg;
      s0 = sh;
      l0 = lt;
      w0 = wt;
      // one whole crt frame: sync edges, blank changes, no panel clocks
      repeat (1280) @(posedge clk_sys_i);
      check("vsync", fr - f0, 1);
      check("blank", tg - t0, 32);
      check("no shift", sh - s0, 0);
      check("hsync", lt - l0, 16);
      check("no weight", wt - w0, 0);
      $display("done crt");
      report_and_stop;
   end
endmodule
bind pcm_display_mux pcm_display_mux_monitor i_mon
(
   .clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
   .power_down_n_i, .host_io_rd_i, .host_io_wr_i, .host_io_addr_i, .panel_or_tube_select_o,
   .pixel_clock_o, .lower_panel_data_o, .palette_read_n_o, .palette_write_n_o
);
